// *** rtl/adcc_regs.svh ***
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
`define ADCC_OFS_CTRL 12'h000
`define ADCC_OFS_RESULT 12'h004
`define ADCC_OFS_STAT 12'h008
`define ADCC_OFS_DATA 12'h00C
`define ADCC_OFS_TIMING 12'h010
`define ADCC_BIT_ON 15
`define ADCC_BIT_IDLE_STOP 13
`define ADCC_FMT_HI 10
`define ADCC_FMT_LO 8
`define ADCC_SRC_HI 7
`define ADCC_SRC_LO 5
`define ADCC_BIT_AUTO_CLR 4
`define ADCC_BIT_AUTO 2
`define ADCC_BIT_SAMPLE 1
`define ADCC_BIT_DONE 0
`define ADCC_CTRL_WMASK 32'h0000A7F7
`define ADCC_CTRL_RESET 32'h00000000
`define ADCC_SAMPLE_CONTROL_CNT_RESET 8'h04
`define ADCC_CONV_CNT_RESET 8'h0C
`endif

// *** rtl/adcc_pkg.sv ***
// types of the converter control block
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_CONVERT
    } adcc_state_t;
    typedef enum logic [2:0] {
        ADCC_TRIG_MANUAL = 3'h0,
        ADCC_TRIG_EXTIRQ = 3'h1,
        ADCC_TRIG_TIMER = 3'h2,
        ADCC_TRIG_CHARGE = 3'h3,
        ADCC_TRIG_AUTO = 3'h7
    } adcc_trig_t;
endpackage

// *** rtl/adcc_control.sv ***
// converter control register, sequencer and result formatting behind an apb slave
//
// Overview of operation
// - converter runs only while enable bit set
// - idle_stop halts operation during chip idle
// - 16-bit integer and fractional result formats
// - 32-bit integer formats, zero or sign fill
// - 32-bit fractional formats, result in top
// - code 111: internal counter ends sampling
// - codes 011 and 010: charge unit, timer match
// - code 001: ext_irq0_pin edge ends sampling
// - code 000: sample_control clear starts conversion
// - writing one to sample_control starts sampling
// - auto_sample_enable sets sample_control by hardware
// - manual mode: writing zero starts conversion
// - hardware trigger clears sample_control itself
// - done flag set when conversion finishes
// - done flag cleared by zero write or at conversion start
// - done clear leaves operation undisturbed
// - done cleared at each conversion start
// - unimplemented control bits read zero
`timescale 1ns/1ps
`include "adcc_regs.svh"

module adcc_control
    import adcc_pkg::*;
(
    input wire logic mclk, // 200 MHz clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic chip_idle, // chip in idle mode
    input wire logic ext_irq0_pin, // external interrupt pin
    input wire logic ext_irq0_rise, // active edge select for the pin
    input wire logic timer3_match, // timer period match pulse
    input wire logic charge_time_unit, // charge-time unit trigger pulse
    input wire logic [9:0] conv_data, // raw converter code
    output logic [31:0] result_word, // formatted result
    output logic conv_start, // pulse at conversion start
    output logic sampling, // sample switch closed
    output logic module_on // converter powered
);

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r;
    logic [7:0] sample_control_cnt_r;
    logic [7:0] conv_cnt_r;
    logic [7:0] tmr_r;
    adcc_state_t state_r;
    logic [2:0] irq_sync_r;
    logic [9:0] data_r;
    logic active;
    logic wr_ctrl;
    logic trig_hit;
    logic conv_end;
    logic sample_control_set;
    logic sample_control_clr_sw;
    logic irq_edge;
    logic [31:0] fmt_nxt;
    logic [31:0] rd_nxt;
    adcc_trig_t trig_sel;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        addr_is = (a == ofs);
    endfunction

    assign trig_sel = adcc_trig_t'(ctrl_r[`ADCC_SRC_HI:`ADCC_SRC_LO]);
    assign active = ctrl_r[`ADCC_BIT_ON] && !(ctrl_r[`ADCC_BIT_IDLE_STOP] && chip_idle);
    assign wr_ctrl = psel && penable && pwrite && addr_is(paddr, `ADCC_OFS_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser, edge detect only on stages two and three
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_sync_r <= 3'h0;
        end else begin
            irq_sync_r <= {irq_sync_r[1:0], ext_irq0_pin};
        end
    end
    assign irq_edge = ext_irq0_rise ? (irq_sync_r[1] && !irq_sync_r[2])
                                    : (!irq_sync_r[1] && irq_sync_r[2]);

    ////////////////////////////////////////////////////////////////////////////
    // trigger selection ending the sampling phase
    always_comb begin
        trig_hit = 1'b0;
        sample_control_clr_sw = wr_ctrl && !pwdata[`ADCC_BIT_SAMPLE];
        unique case (trig_sel)
            ADCC_TRIG_MANUAL: trig_hit = sample_control_clr_sw;
            ADCC_TRIG_EXTIRQ: trig_hit = irq_edge;
            ADCC_TRIG_TIMER: trig_hit = timer3_match;
            ADCC_TRIG_CHARGE: trig_hit = charge_time_unit;
            ADCC_TRIG_AUTO: trig_hit = (sample_control_cnt_r == 8'h00);
            default: trig_hit = 1'b0;
        endcase
    end

    assign conv_end = (state_r == ADCC_CONVERT) && (conv_cnt_r == 8'h00);
    assign sample_control_set = (state_r == ADCC_IDLE) && active
        && ((wr_ctrl && pwdata[`ADCC_BIT_SAMPLE]) || ctrl_r[`ADCC_BIT_AUTO]);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ADCC_IDLE;
        end else if (!active) begin
            state_r <= ADCC_IDLE;
        end else begin
            unique case (state_r)
                ADCC_IDLE: begin
                    if (sample_control_set) begin
                        state_r <= ADCC_SAMPLE;
                    end
                end
                ADCC_SAMPLE: begin
                    if (trig_hit) begin
                        state_r <= ADCC_CONVERT;
                    end
                end
                ADCC_CONVERT: begin
                    if (conv_end) begin
                        state_r <= ADCC_IDLE;
                    end
                end
            endcase
        end
    end

    // sample and conversion timers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sample_control_cnt_r <= `ADCC_SAMPLE_CONTROL_CNT_RESET;
            conv_cnt_r <= `ADCC_CONV_CNT_RESET;
        end else begin
            if (state_r != ADCC_SAMPLE) begin
                sample_control_cnt_r <= tmr_r;
            end else if (sample_control_cnt_r != 8'h00) begin
                sample_control_cnt_r <= sample_control_cnt_r - 8'h01;
            end
            if (state_r != ADCC_CONVERT) begin
                conv_cnt_r <= `ADCC_CONV_CNT_RESET;
            end else if (conv_cnt_r != 8'h00) begin
                conv_cnt_r <= conv_cnt_r - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tmr_r <= `ADCC_SAMPLE_CONTROL_CNT_RESET;
        end else if (psel && penable && pwrite && addr_is(paddr, `ADCC_OFS_TIMING)) begin
            tmr_r <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register with hardware-owned sample and done bits
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r <= `ADCC_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r[15:2] <= pwdata[15:2] & 14'(`ADCC_CTRL_WMASK >> 2);
            end
            // sample_control follows the sequencer
            if (active && state_r == ADCC_SAMPLE && trig_hit) begin
                ctrl_r[`ADCC_BIT_SAMPLE] <= 1'b0;
            end else if (sample_control_set) begin
                ctrl_r[`ADCC_BIT_SAMPLE] <= 1'b1;
            end else if (!active) begin
                ctrl_r[`ADCC_BIT_SAMPLE] <= 1'b0;
            end
            // done: set wins over software clear
            if (active && conv_end) begin
                ctrl_r[`ADCC_BIT_DONE] <= 1'b1;
                if (ctrl_r[`ADCC_BIT_AUTO_CLR]) begin
                    ctrl_r[`ADCC_BIT_AUTO] <= 1'b0;
                end
            end else if (active && state_r == ADCC_SAMPLE && trig_hit) begin
                ctrl_r[`ADCC_BIT_DONE] <= 1'b0;
            end else if (wr_ctrl && !pwdata[`ADCC_BIT_DONE]) begin
                ctrl_r[`ADCC_BIT_DONE] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result formatting
    always_comb begin
        fmt_nxt = 32'h00000000;
        unique case (ctrl_r[`ADCC_FMT_HI:`ADCC_FMT_LO])
            3'h2: fmt_nxt = {16'h0000, data_r, 6'h00};
            3'h3: fmt_nxt = {16'h0000, ~data_r[9], data_r[8:0], 6'h00};
            3'h4: fmt_nxt = {22'h000000, data_r};
            3'h5: fmt_nxt = {{22{~data_r[9]}}, ~data_r[9], data_r[8:0]};
            3'h6: fmt_nxt = {data_r, 22'h000000};
            3'h7: fmt_nxt = {~data_r[9], data_r[8:0], 22'h000000};
            default: fmt_nxt = {22'h000000, data_r};
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            data_r <= 10'h000;
            result_word <= 32'h00000000;
        end else begin
            if (active && conv_end) begin
                data_r <= conv_data;
            end
            result_word <= fmt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    always_comb begin
        rd_nxt = 32'h00000000;
        if (addr_is(paddr, `ADCC_OFS_CTRL)) begin
            rd_nxt = ctrl_r & `ADCC_CTRL_WMASK;
        end else if (addr_is(paddr, `ADCC_OFS_RESULT)) begin
            rd_nxt = fmt_nxt;
        end else if (addr_is(paddr, `ADCC_OFS_STAT)) begin
            rd_nxt = {28'h0000000, irq_sync_r[1], active, state_r};
        end else if (addr_is(paddr, `ADCC_OFS_DATA)) begin
            rd_nxt = {22'h000000, data_r};
        end else if (addr_is(paddr, `ADCC_OFS_TIMING)) begin
            rd_nxt = {24'h000000, tmr_r};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h00000000;
            pslverr <= psel && !penable && (paddr > `ADCC_OFS_TIMING || paddr[1:0] != 2'h0);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            conv_start <= 1'b0;
            sampling <= 1'b0;
            module_on <= 1'b0;
        end else begin
            conv_start <= active && state_r == ADCC_SAMPLE && trig_hit;
            sampling <= active && (state_r == ADCC_SAMPLE || sample_control_set);
            module_on <= active;
        end
    end

endmodule // adcc_control

// *** verif/adcc_control_sva.sv ***
// assertions on the ports of the converter control
`timescale 1ns/1ps
module adcc_control_sva (
    input wire logic mclk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic chip_idle, // chip idle
    input wire logic timer3_match, // timer pulse
    input wire logic charge_time_unit, // charge unit pulse
    input wire logic conv_start, // start pulse
    input wire logic sampling, // sampling level
    input wire logic module_on // converter on
);
    logic [2:0] src_r;
    logic stop_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // shadow of trigger select and idle stop
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            src_r <= 3'h0;
            stop_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
            src_r <= pwdata[7:5];
            stop_r <= pwdata[13];
        end
    end
    sequence s_idle_held;
        stop_r && chip_idle ##1 stop_r && chip_idle;
    endsequence
    sequence s_hw_trig;
        sampling && module_on && ((src_r == 3'h2 && timer3_match) ||
            (src_r == 3'h3 && charge_time_unit));
    endsequence
    ////////////////////////////////////////
    a_read_zero: assert property (pready && !pwrite && paddr == 12'h000 |->
        prdata[31:16] == 16'h0 && !prdata[14] && prdata[12:11] == 2'h0)
        else $error("unimplemented control bits not zero");
    a_off_quiet: assert property ($fell(module_on) |-> ##2 !sampling)
        else $error("sampling while converter off");
    a_idle_halt: assert property (s_idle_held |-> !module_on)
        else $error("converter runs in idle with idle stop");
    a_hw_trig: assert property (s_hw_trig |-> ##[1:2] conv_start)
        else $error("hardware trigger did not start conversion");
    a_start_cause: assert property (conv_start |-> $past(sampling))
        else $error("conversion start without sampling");
    a_sample_control_drop: assert property (conv_start |=> !sampling [*8])
        else $error("sampling during conversion");
    a_conv_len: assert property (conv_start |=> !conv_start [*8])
        else $error("conversion restarted too early");
    a_no_rsvd: assert property (src_r inside {3'h4, 3'h5, 3'h6} && $past(src_r, 2) == src_r
        |-> !conv_start) else $error("reserved trigger started conversion");
endmodule // adcc_control_sva
bind adcc_control adcc_control_sva u_adcc_control_sva (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .chip_idle(chip_idle), .timer3_match(timer3_match),
    .charge_time_unit(charge_time_unit), .conv_start(conv_start), .sampling(sampling),
    .module_on(module_on));

// *** verif/adcc_control_test.sv ***
// self-checking bench for the converter control
`timescale 1ns/1ps
module adcc_control_test;
    localparam logic [31:0] ON = 32'h00008000;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic chip_idle = 1'b0, ext_irq0_pin = 1'b0, timer3_match = 1'b0, charge_time_unit = 1'b0;
    logic irq_rise = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, result_word, rd;
    logic [9:0] conv_data = 10'h0C5;
    logic pready, pslverr, conv_start, sampling, module_on;
    int errors = 0, samples_checked = 0, starts = 0;
    adcc_control u_adcc_control (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_idle(chip_idle), .ext_irq0_pin(ext_irq0_pin),
        .ext_irq0_rise(irq_rise), .timer3_match(timer3_match), .charge_time_unit(charge_time_unit),
        .conv_data(conv_data), .result_word(result_word), .conv_start(conv_start),
        .sampling(sampling), .module_on(module_on));
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (conv_start === 1'b1) starts++;
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h000, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 12);
    endtask
    task automatic fire(input logic [2:0] m);
        {ext_irq0_pin, timer3_match, charge_time_unit} <= m;
        @(posedge mclk);
        {ext_irq0_pin, timer3_match, charge_time_unit} <= 3'h0;
    endtask
    ////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b1, 12'h000, 32'hFFFF7FF8);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl bits", rd, 32'h000027F0);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h000, 32'h0);
        $display("regs test done");
    endtask
    task automatic t_formats;
        logic [9:0] s;
        logic [31:0] e;
        s = {~conv_data[9], conv_data[8:0]};
        for (int f = 0; f < 8; f++) begin
            apb(1'b1, 12'h000, ON | (f << 8) | 32'h1);
            apb(1'b0, 12'h000, 32'h0);
            chk("done kept", rd & 32'h1, (f > 0) ? 32'h1 : 32'h0);
            apb(1'b1, 12'h000, ON | (f << 8) | 32'h3);
            apb(1'b1, 12'h000, ON | (f << 8) | 32'h1);
            apb(1'b0, 12'h000, 32'h0);
            chk("sample_control and done at start", rd & 32'h3, 32'h0);
            apb(1'b1, 12'h000, ON | (f << 8));
            wait_done;
            chk("done", rd & 32'h1, 32'h1);
            case (f)
                2: e = {16'h0, conv_data, 6'h0};
                3: e = {16'h0, s, 6'h0};
                5: e = {{22{s[9]}}, s};
                6: e = {conv_data, 22'h0};
                7: e = {s, 22'h0};
                default: e = {22'h0, conv_data};
            endcase
            repeat (2) @(posedge mclk);
            chk("result", result_word, e);
            apb(1'b0, 12'h004, 32'h0);
            chk("result reg", rd, e);
        end
        $display("format test done");
    endtask
    task automatic t_triggers;
        logic [2:0] src;
        int c;
        for (int k = 0; k < 5; k++) begin
            src = (k == 3) ? 3'h7 : ((k == 4) ? 3'h1 : 3'(k + 1));
            irq_rise <= (k != 4);
            c = starts;
            apb(1'b1, 12'h000, ON | (src << 5) | 32'h2);
            repeat (3) @(posedge mclk);
            fire(3'h4 >> (src - 3'h1));
            wait_done;
            chk("hw clears sample_control", rd & 32'h3, 32'h1);
            chk("one start", starts - c, 32'h1);
        end
        apb(1'b1, 12'h000, ON | 32'hA2);
        repeat (3) @(posedge mclk);
        fire(3'h7);
        repeat (30) @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("reserved source", rd & 32'h3, 32'h2);
        $display("trigger test done");
    endtask
    task automatic t_auto;
        int c;
        c = starts;
        apb(1'b1, 12'h000, ON | 32'hE4);
        repeat (120) @(posedge mclk);
        chk("auto restarts", starts - c >= 4, 32'h1);
        apb(1'b1, 12'h000, ON | 32'hE0);
        repeat (20) @(posedge mclk);
        c = starts;
        apb(1'b1, 12'h000, ON | 32'hF4);
        repeat (60) @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("auto clear starts", starts - c, 32'h1);
        chk("auto clear bits", rd & 32'h17, 32'h11);
        $display("auto test done");
    endtask
    task automatic t_idle;
        apb(1'b1, 12'h000, ON | 32'h2000);
        chip_idle <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("idle stop", module_on, 32'h0);
        apb(1'b1, 12'h000, ON);
        repeat (3) @(posedge mclk);
        chk("idle run", module_on, 32'h1);
        chip_idle <= 1'b0;
        apb(1'b1, 12'h000, 32'h2);
        repeat (3) @(posedge mclk);
        chk("off", {module_on, sampling}, 32'h0);
        $display("idle test done");
    endtask
    task automatic close_out;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs;
        t_formats;
        t_triggers;
        t_auto;
        t_idle;
        close_out;
    end
    initial begin
        #20000;
        errors++;
        close_out;
    end
endmodule // adcc_control_test
